// *** verilog/adcsp_pkg.sv ***
// Package with the constants and types of the converter serial interface.
package adcsp_pkg;

    // ========================================================================
    // Frame sizes
    localparam int unsigned CMD_BITS      = 22;
    localparam int unsigned OPT_READ_BITS = 20;
    localparam logic [4:0]  CMD_MIN_CLKS  = 5'h16;
    localparam logic [4:0]  CNT_SAT       = 5'h1f;
    localparam int unsigned SYNC_STAGES   = 2;

    // ========================================================================
    // Clocking modes of write frames: bit 1 is idle level, capture edge per code
    localparam logic [1:0] WMODE_00 = 2'h0;
    localparam logic [1:0] WMODE_01 = 2'h1;
    localparam logic [1:0] WMODE_10 = 2'h2;
    localparam logic [1:0] WMODE_11 = 2'h3;

    // ========================================================================
    // Read output modes, lane widths and strobe sources
    localparam logic [1:0] RMODE_STD   = 2'h0;
    localparam logic [1:0] RMODE_EARLY = 2'h1;
    localparam logic [1:0] RMODE_SRC   = 2'h3;
    localparam logic [1:0] WIDTH_DUAL  = 2'h2;
    localparam logic [1:0] WIDTH_QUAD  = 2'h3;
    localparam logic [1:0] STRB_ECHO   = 2'h0;

    // ========================================================================
    // Values after reset
    localparam logic [1:0]  RST_WMODE = WMODE_00;
    localparam logic [1:0]  RST_RMODE = RMODE_STD;
    localparam logic [1:0]  RST_WIDTH = 2'h0;
    localparam logic [21:0] RST_WORD  = 22'h000000;

    typedef enum logic [0:0] {
        ADCSP_IDLE  = 1'h0,
        ADCSP_FRAME = 1'h1
    } adcsp_state_t;

endpackage

// *** verilog/adcsp_pin_if.sv ***
// Interface carrying synchronised pin levels and their edges.
`timescale 1ns/100ps
`default_nettype none
interface adcsp_pin_if;
    logic cs_n;
    logic sclk;
    logic sdi;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;

    modport src (output cs_n, sclk, sdi, cs_fall, cs_rise, sclk_rise, sclk_fall);
    modport dst (input  cs_n, sclk, sdi, cs_fall, cs_rise, sclk_rise, sclk_fall);
endinterface
`default_nettype wire

// *** verilog/adcsp_pin_sync.sv ***
// Two-stage synchronisers and edge finders for the host-driven pins.
`timescale 1ns/100ps
`default_nettype none
module adcsp_pin_sync (
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     resetn_i,
    input  wire logic     clk_en_i,
    // Raw pins
    input  wire logic     cs_n_i,
    input  wire logic     sclk_i,
    input  wire logic     sdi_i,
    // Synchronised view
    adcsp_pin_if.src      pin
);

    // ========================================================================
    // Synchronisers
    // The first stage feeds only the second; edges compare stage two and three.
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [1:0] last_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= 3'h1;
            sync_q <= 3'h1;
            last_q <= 2'h1;
        end else if (clk_en_i) begin
            meta_q <= {sdi_i, sclk_i, cs_n_i};
            sync_q <= meta_q;
            last_q <= sync_q[1:0];
        end
    end

    assign pin.cs_n      = sync_q[0];
    assign pin.sclk      = sync_q[1];
    assign pin.sdi       = sync_q[2];
    assign pin.cs_fall   = last_q[0] & ~sync_q[0];
    assign pin.cs_rise   = ~last_q[0] & sync_q[0];
    assign pin.sclk_rise = ~last_q[1] & sync_q[1];
    assign pin.sclk_fall = last_q[1] & ~sync_q[1];

endmodule
`default_nettype wire

// *** verilog/adcsp_serial_if.sv ***
// Device-side serial frame engine of the converter host interface.
`timescale 1ns/100ps
`default_nettype none
module adcsp_serial_if (
    // Clock, reset and enable
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        clk_en_i,
    // Host pins
    input  wire logic        cs_n_i,
    input  wire logic        sclk_i,
    input  wire logic        sdi_i,
    output logic [3:0]       serial_output_lanes_o,
    output logic [3:0]       serial_output_lanes_oe_o,
    output logic             ready_strobe_o,
    // Protocol settings from the configuration registers
    input  wire logic [1:0]  write_clocking_select_i,
    input  wire logic [1:0]  read_output_mode_select_i,
    input  wire logic [1:0]  output_width_select_i,
    input  wire logic        double_rate_i,
    input  wire logic [1:0]  strobe_clock_source_select_i,
    // Output data word and decoded command
    input  wire logic [21:0] out_word_i,
    output logic [21:0]      cmd_word_o,
    output logic             cmd_valid_o,
    output logic             strobe_src_unsupported_o
);

    adcsp_pin_if pin ();

    adcsp_pin_sync u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .clk_en_i (clk_en_i),
        .cs_n_i   (cs_n_i),
        .sclk_i   (sclk_i),
        .sdi_i    (sdi_i),
        .pin      (pin)
    );

    // ========================================================================
    // Helpers
    function automatic logic [3:0] lane_mask(input logic [1:0] width);
        case (width)
            adcsp_pkg::WIDTH_DUAL: lane_mask = 4'h3;
            adcsp_pkg::WIDTH_QUAD: lane_mask = 4'hf;
            default:               lane_mask = 4'h1;
        endcase
    endfunction

    function automatic logic [21:0] shift_out(input logic [21:0] w, input logic [1:0] width);
        case (width)
            adcsp_pkg::WIDTH_DUAL: shift_out = {w[19:0], 2'h0};
            adcsp_pkg::WIDTH_QUAD: shift_out = {w[17:0], 4'h0};
            default:               shift_out = {w[20:0], 1'h0};
        endcase
    endfunction

    // ========================================================================
    // Frame state and per-frame protocol
    adcsp_pkg::adcsp_state_t state_q;
    logic [1:0]  wmode_q;
    logic [1:0]  rmode_q;
    logic [1:0]  width_q;
    logic        ddr_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= adcsp_pkg::ADCSP_IDLE;
        end else if (clk_en_i) begin
            case (state_q)
                adcsp_pkg::ADCSP_IDLE:  if (pin.cs_fall) state_q <= adcsp_pkg::ADCSP_FRAME;
                adcsp_pkg::ADCSP_FRAME: if (pin.cs_rise) state_q <= adcsp_pkg::ADCSP_IDLE;
                default:                state_q <= adcsp_pkg::ADCSP_IDLE;
            endcase
        end
    end

    // Clocking, read mode, width and rate settings are sampled only at frame start, so a mode written during a
    // frame takes effect from the next frame on.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wmode_q <= adcsp_pkg::RST_WMODE;
            rmode_q <= adcsp_pkg::RST_RMODE;
            width_q <= adcsp_pkg::RST_WIDTH;
            ddr_q   <= 1'b0;
        end else if (clk_en_i && pin.cs_fall) begin
            wmode_q <= write_clocking_select_i;
            rmode_q <= read_output_mode_select_i;
            width_q <= output_width_select_i;
            ddr_q   <= double_rate_i;
        end
    end

    logic in_frame;
    logic cap_rise;
    logic cap_ev;
    logic launch_ev;
    logic early;
    logic src_mode;
    logic shift_ev;

    assign in_frame  = (state_q == adcsp_pkg::ADCSP_FRAME) && !pin.cs_rise;
    // Modes 00 and 11 capture on rising edges, 01 and 10 on falling ones.
    assign cap_rise  = (wmode_q == adcsp_pkg::WMODE_00) || (wmode_q == adcsp_pkg::WMODE_11);
    assign cap_ev    = in_frame && (cap_rise ? pin.sclk_rise : pin.sclk_fall);
    assign launch_ev = in_frame && (cap_rise ? pin.sclk_fall : pin.sclk_rise);
    // Early launch only exists for the modes that launch their MSB at frame start.
    assign early     = (rmode_q == adcsp_pkg::RMODE_EARLY) && !wmode_q[0];
    assign src_mode  = (rmode_q == adcsp_pkg::RMODE_SRC);
    always_comb begin
        if (src_mode && ddr_q) begin
            shift_ev = in_frame && (pin.sclk_rise || pin.sclk_fall);
        end else if (early) begin
            shift_ev = cap_ev;
        end else begin
            shift_ev = launch_ev;
        end
    end

    // ========================================================================
    // Output shift register
    logic [21:0] odr_q;
    logic        primed_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            odr_q    <= adcsp_pkg::RST_WORD;
            primed_q <= 1'b0;
        end else if (clk_en_i) begin
            if (pin.cs_fall) begin
                odr_q    <= out_word_i;
                primed_q <= ~write_clocking_select_i[0];
            end else if (shift_ev) begin
                // Modes 01 and 11 present the MSB on the first launch edge.
                if (primed_q) begin
                    odr_q <= shift_out(odr_q, width_q);
                end
                primed_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_output_lanes_o    <= 4'h0;
            serial_output_lanes_oe_o <= 4'h0;
        end else if (clk_en_i) begin
            serial_output_lanes_o    <= {odr_q[18], odr_q[19], odr_q[20], odr_q[21]}
                                        & lane_mask(width_q);
            serial_output_lanes_oe_o <= in_frame ? lane_mask(width_q) : 4'h0;
        end
    end

    // ========================================================================
    // Ready and strobe pin
    // The clock copy takes one stage so that the strobe edge lines up with
    // the lane register, which also lags the shift by one cycle.
    logic sclk_dly_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_dly_q               <= 1'b0;
            ready_strobe_o           <= 1'b1;
            strobe_src_unsupported_o <= 1'b0;
        end else if (clk_en_i) begin
            sclk_dly_q <= pin.sclk;
            if (!in_frame) begin
                ready_strobe_o <= 1'b1;
            end else if (src_mode) begin
                // Only the echoed host clock is offered as strobe source.
                ready_strobe_o <= sclk_dly_q;
            end else begin
                ready_strobe_o <= 1'b0;
            end
            strobe_src_unsupported_o <= src_mode &&
                                        (strobe_clock_source_select_i != adcsp_pkg::STRB_ECHO);
        end
    end

    // ========================================================================
    // Input shift register and command hand-off
    logic [21:0] idr_q;
    logic [4:0]  cnt_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            idr_q <= adcsp_pkg::RST_WORD;
            cnt_q <= 5'h0;
        end else if (clk_en_i) begin
            if (pin.cs_fall) begin
                idr_q <= adcsp_pkg::RST_WORD;
                cnt_q <= 5'h0;
            end else if (cap_ev) begin
                idr_q <= {idr_q[20:0], pin.sdi};
                if (cnt_q != adcsp_pkg::CNT_SAT) begin
                    cnt_q <= cnt_q + 5'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_word_o  <= adcsp_pkg::RST_WORD;
            cmd_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            cmd_valid_o <= 1'b0;
            if ((state_q == adcsp_pkg::ADCSP_FRAME) && pin.cs_rise &&
                (cnt_q >= adcsp_pkg::CMD_MIN_CLKS)) begin
                cmd_word_o  <= idr_q;
                cmd_valid_o <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// *** bench/adcsp_serial_if_props.sv ***
// Concurrent checks on the ports of the serial frame engine.
`timescale 1ns/100ps
`default_nettype none
module adcsp_serial_if_props (
    // Watched ports
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        cs_n_i,
    input wire logic        sclk_i,
    input wire logic [1:0]  read_output_mode_select_i,
    input wire logic [1:0]  output_width_select_i,
    input wire logic [3:0]  serial_output_lanes_oe_o,
    input wire logic        ready_strobe_o,
    input wire logic [21:0] cmd_word_o,
    input wire logic        cmd_valid_o,
    input wire logic        strobe_src_unsupported_o
);
    // ==========
    // Clock edges seen in the current frame
    logic [6:0] tog_q;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            tog_q <= 7'h00;
        else if ($fell(cs_n_i))
            tog_q <= 7'h00;
        else if (!cs_n_i && $changed(sclk_i) && tog_q != 7'h7f)
            tog_q <= tog_q + 7'h01;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    property p_release;
        cs_n_i [*8] |-> serial_output_lanes_oe_o == 4'h0;
    endproperty
    property p_start;
        $fell(cs_n_i) |-> ##[2:8] serial_output_lanes_oe_o != 4'h0;
    endproperty
    property p_frame_strobe;
        (!cs_n_i && read_output_mode_select_i != adcsp_pkg::RMODE_SRC) [*8] |-> !ready_strobe_o;
    endproperty
    property p_width;
        !cs_n_i [*8] |-> serial_output_lanes_oe_o ==
            (output_width_select_i == adcsp_pkg::WIDTH_QUAD ? 4'hf :
             output_width_select_i == adcsp_pkg::WIDTH_DUAL ? 4'h3 : 4'h1);
    endproperty
    property p_echo;
        !cs_n_i [*6] ##1 ($changed(sclk_i) && read_output_mode_select_i == adcsp_pkg::RMODE_SRC)
            |-> ##[2:7] ready_strobe_o == sclk_i;
    endproperty
    property p_pulse;
        cmd_valid_o |=> !cmd_valid_o;
    endproperty
    // An edge count of 43 separates a 21-clock frame from a 22-clock one in any mode.
    property p_count;
        cmd_valid_o |-> cs_n_i && tog_q >= 7'h2b;
    endproperty
    property p_hold;
        !cmd_valid_o |-> $stable(cmd_word_o);
    endproperty
    a_release: assert property (p_release) else $error("lanes driven outside frame");
    a_start: assert property (p_start) else $error("lanes not driven at frame start");
    a_frame_strobe: assert property (p_frame_strobe) else $error("strobe high in frame");
    a_width: assert property (p_width) else $error("lane enables wrong");
    a_echo: assert property (p_echo) else $error("strobe does not echo clock");
    a_pulse: assert property (p_pulse) else $error("command pulse too long");
    a_count: assert property (p_count) else $error("command from short frame");
    a_hold: assert property (p_hold) else $error("command word moved");
    cover property (cmd_valid_o);
    cover property (serial_output_lanes_oe_o == 4'hf);
    cover property (strobe_src_unsupported_o);
endmodule
`default_nettype wire

// *** bench/adcsp_host_model.sv ***
// Host controller model that runs frames on the serial pins.
`timescale 1ns/100ps
`default_nettype none
module adcsp_host_model (
    // Clock and device lanes
    input  wire logic       clk_i,
    input  wire logic [3:0] lanes_i,
    input  wire logic [3:0] oe_i,
    // Host pins
    output logic            cs_n_o,
    output logic            sclk_o,
    output logic            sdi_o
);
    // ==========
    // Frame engine
    // A released lane reads as the inverse of its value, so stale data never passes.
    wire logic [3:0] lane_w = (oe_i & lanes_i) | (~oe_i & ~lanes_i);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
    end
    task automatic frame(input logic [1:0] m, input int n, input logic [31:0] w,
                         input int wd, input bit early, output logic [31:0] rd);
        logic cap;
        int   j;
        cap = (m == 2'h0) || (m == 2'h3);
        j = 0;
        rd = 32'h0;
        sclk_o = m[1];
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b0;
        if (!m[0]) begin
            sdi_o = w[n - 1];
            j = 1;
        end
        repeat (8) @(negedge clk_i);
        // A fixed, short frame keeps the read inside the zone it was started in.
        for (int i = 0; i < 2 * n; i++) begin
            sclk_o = ~sclk_o;
            if (sclk_o == (cap ^ early))
                rd = (rd << wd) | 32'({lane_w[0], lane_w[1], lane_w[2], lane_w[3]} >> (4 - wd));
            if (sclk_o != cap && j < n) begin
                sdi_o = w[n - 1 - j];
                j++;
            end
            repeat (8) @(negedge clk_i);
        end
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        rd = rd << (32 - n * wd);
        repeat (20) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** bench/adcsp_serial_if_tb_top.sv ***
// Self-checking bench for the converter serial frame engine.
`timescale 1ns/100ps
`default_nettype none
module adcsp_serial_if_tb_top;
    logic        clk_i;
    logic        resetn_i;
    logic        cs_n;
    logic        sclk;
    logic        sdi;
    logic        strobe;
    logic        valid;
    logic        unsup;
    logic        ddr;
    logic [3:0]  lanes;
    logic [3:0]  oe;
    logic [1:0]  wmode;
    logic [1:0]  rmode;
    logic [1:0]  width;
    logic [1:0]  src;
    logic [21:0] oword;
    logic [21:0] cmd;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          n_valid = 0;
    int          v0;
    adcsp_serial_if adcsp_serial_if_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .cs_n_i(cs_n), .sclk_i(sclk),
        .sdi_i(sdi), .serial_output_lanes_o(lanes), .serial_output_lanes_oe_o(oe),
        .ready_strobe_o(strobe), .write_clocking_select_i(wmode),
        .read_output_mode_select_i(rmode), .output_width_select_i(width), .double_rate_i(ddr),
        .strobe_clock_source_select_i(src), .out_word_i(oword), .cmd_word_o(cmd),
        .cmd_valid_o(valid), .strobe_src_unsupported_o(unsup));
    adcsp_host_model adcsp_host_model_inst (
        .clk_i(clk_i), .lanes_i(lanes), .oe_i(oe), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
    // ==========
    // Shared tasks
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_reset();
        resetn_i = 1'b0;
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        cmp(32'h4, {oe, strobe, valid, unsup});
    endtask
    task automatic run(input int n, input logic [31:0] w, input int wd, input bit e);
        v0 = n_valid;
        adcsp_host_model_inst.frame(wmode, n, w, wd, e, rd);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (valid === 1'b1) n_valid++;
    initial begin
        #200us;
        n_mismatch++;
        stop_test();
    end
    // ==========
    // Scenarios
    initial begin
        {wmode, rmode, width, src, ddr} = 9'h000;
        oword = 22'h2b5a3c;
        do_reset();
        for (int m = 0; m < 4; m++) begin
            wmode = 2'(m);
            oword = 22'h2b5a3c ^ 22'(m * 5);
            run(22, 32'h0c3a5 + m, 1, 1'b0);
            cmp(32'h0c3a5 + m, 32'(cmd));
            cmp(1, n_valid - v0);
            cmp(32'(oword[21:2]), 32'(rd[31:12]));
        end
        wmode = 2'h0;
        run(21, 32'h1fffff, 1, 1'b0);
        cmp(32'h0c3a8, 32'(cmd));
        cmp(0, n_valid - v0);
        run(24, 32'habcdef, 1, 1'b0);
        cmp(32'h2bcdef, 32'(cmd));
        cmp(32'(oword[21:2]), 32'(rd[31:12]));
        for (int k = 2; k < 4; k++) begin
            width = 2'(k);
            run(k == 2 ? 11 : 6, 32'h0, k == 2 ? 2 : 4, 1'b0);
            cmp(32'(oword[21:2]), 32'(rd[31:12]));
        end
        width = 2'h0;
        rmode = adcsp_pkg::RMODE_EARLY;
        run(22, 32'h155aa, 1, 1'b1);
        cmp(32'(oword[20:1]), 32'(rd[31:12]));
        cmp(32'h155aa, 32'(cmd));
        rmode = adcsp_pkg::RMODE_SRC;
        src = 2'h1;
        ddr = 1'b1;
        run(22, 32'h0f0f0, 1, 1'b0);
        cmp(1, unsup);
        cmp(32'h0f0f0, 32'(cmd));
        src = adcsp_pkg::STRB_ECHO;
        run(22, 32'h0, 1, 1'b0);
        cmp(0, unsup);
        {rmode, ddr} = 3'h0;
        do_reset();
        stop_test();
    end
endmodule
bind adcsp_serial_if adcsp_serial_if_props adcsp_serial_if_props_inst (
    .clk_i, .resetn_i, .cs_n_i, .sclk_i, .read_output_mode_select_i, .output_width_select_i,
    .serial_output_lanes_oe_o, .ready_strobe_o, .cmd_word_o, .cmd_valid_o,
    .strobe_src_unsupported_o);
`default_nettype wire
